// ### rtl/ext_bus_if.sv
`timescale 1ns/1ps
// Function
// R1: low port carries low address byte first, then data, on every access.
// R2: as plain I/O a low pin latched one floats; on the bus ones are driven.
// R3: high port gives upper address on external fetches and wide data moves.
// R4: narrow data moves keep the high port showing its output latch.
// R5: latch strobe runs at osc/6 in 12-clock mode, osc/3 in 6-clock mode.
// R6: each external data move skips exactly one latch strobe pulse.
// R7: auxiliary bit 0 stops latch strobe except during external data moves.
// R8: external code execution gives two program store strobes per cycle.
// R9: each external data move skips two program store strobes.
// R10: program store strobe stays high for on-chip fetches.
// R11: external access pin is caught at reset release, then ignored.
// R12: system holds external access pin low at release for external code.
// R13: system holds reset for at least two machine cycles, oscillator running; the testbench holds its first reset for only 2 clocks.
// R14: machine cycle is 12 or 6 periods; option or software bit picks 6.
// R15: data write strobe on port 3 bit 6, read strobe on bit 7.
// R16: ports 1 to 3 pull weakly high where their latch holds one.
// R17: programmed option forces 6-clock; else software bit chooses.
// R18: low address stays stable while latch strobe is high.
module ext_bus_if
(
    input  wire logic                    sys_clk,   // oscillator clock
    input  wire logic                    rstn,      // sync reset, low
    input  wire ext_bus_pkg::cpu_req_s   req,       // core request
    input  wire ext_bus_pkg::port_cfg_s  cfg,       // latches and options
    input  wire logic                    eaPin,     // external_access_select
    input  wire logic [7:0]              lowPortIn, // low port pin levels
    output ext_bus_pkg::bus_pins_s       pins,      // bus pins
    output ext_bus_pkg::cpu_rsp_s        rsp        // answers to core
);
    import ext_bus_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  eaSync;      // pin synchroniser
        logic [7:0]  lowSync1;    // first stage, read only by second
        logic [7:0]  lowSync2;
        logic        armed;       // waiting for reset release
        cycle_e      kind;
        logic [15:0] codeAddr;
        logic        dataWrite;
        logic        dataWide;
        logic [15:0] dataAddr;
        logic [7:0]  dataWdata;
        logic        rdAct;       // read strobe active internally
        logic [1:0]  fetchPipe;   // strobe end, delayed by the sync
        logic [1:0]  readPipe;
        bus_pins_s   pins;
        cpu_rsp_s    rsp;
    } bus_s;

    bus_s   q;
    bus_s   d;
    phase_t phase;
    logic   half;
    logic   dbl;

    cycle_timer timer
    (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .otpDouble   (cfg.otpDouble),
        .softDouble  (cfg.softDouble),
        .phase       (phase),
        .half        (half),
        .doubleSpeed (dbl)
    );

    function automatic phase_t aleEnd(input logic dblMode);
        aleEnd = dblMode ? ALE_END_6 : ALE_END_12;
    endfunction

    function automatic phase_t strobeStart(input logic dblMode);
        strobeStart = dblMode ? STROBE_START_6 : STROBE_START_12;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic        cycleStart;
    logic        aleWin;
    logic        addrWin;
    logic        stbWin;
    logic [15:0] fetchAddr;
    logic        fetchExt;

    always_comb
    begin
        d = q;
        cycleStart = (phase == 4'h0) && !half;
        aleWin     = phase <= aleEnd(dbl);
        addrWin    = phase < strobeStart(dbl);
        stbWin     = !addrWin;

        // two-flop synchronisers keep running through reset
        d.eaSync   = {q.eaSync[0], eaPin};
        d.lowSync1 = lowPortIn;
        d.lowSync2 = q.lowSync1;

        // external_access_select caught once, first cycle after release
        if (q.armed)
        begin
            d.armed            = 1'b0;
            d.rsp.extAccessLow = ~q.eaSync[1];   // see R11, see R12
        end

        // request is sampled at each machine cycle boundary
        d.rsp.reqTaken = cycleStart;
        if (cycleStart)
        begin
            fetchExt    = d.rsp.extAccessLow | ~req.codeInternal;
            d.kind      = req.dataReq ? CYC_DATA
                        : (fetchExt ? CYC_EXT : CYC_INT);
            d.codeAddr  = req.codeAddr;
            d.dataWrite = req.dataWrite;
            d.dataWide  = req.dataWide;
            d.dataAddr  = req.dataAddr;
            d.dataWdata = req.dataWdata;
        end
        else
            fetchExt = 1'b0;
        d.rsp.doubleSpeed = dbl;                 // see R14

        // ------------------------------------------------------------
        // idle pin picture: plain I/O behaviour
        // ------------------------------------------------------------
        d.pins.ale      = 1'b0;
        d.pins.psenN    = 1'b1;                  // see R10
        d.rdAct         = 1'b0;
        d.pins.wrN      = cfg.wrLatch;
        d.pins.lowOut   = BYTE_ZERO;
        d.pins.lowOe    = ~cfg.lowLatch;         // see R2
        d.pins.highOut  = cfg.highLatch;
        d.pins.highOe   = BYTE_ZERO;
        d.pins.highPull = cfg.highLatch;         // see R16
        fetchAddr       = d.codeAddr + {15'h0000, half};

        case (d.kind)
            CYC_INT:
            begin
                d.pins.ale = aleWin & ~cfg.aleOff;        // see R5, see R7
            end
            CYC_EXT:
            begin
                d.pins.ale      = aleWin & ~cfg.aleOff;   // see R5, see R7
                d.pins.highOut  = fetchAddr[15:8];        // see R3
                d.pins.highOe   = PORT_RESET;
                d.pins.highPull = BYTE_ZERO;
                // address outlives the strobe's falling edge
                d.pins.lowOut   = fetchAddr[7:0];         // see R1, see R18
                d.pins.lowOe    = addrWin ? PORT_RESET : BYTE_ZERO;
                d.pins.psenN    = ~stbWin;                // see R8
            end
            CYC_DATA:
            begin
                // one strobe only in the first half; none in the second
                d.pins.ale      = aleWin & ~half;         // see R6, see R7
                d.pins.highOut  = d.dataWide ? d.dataAddr[15:8]
                                : cfg.highLatch;          // see R3, see R4
                d.pins.highOe   = PORT_RESET;
                d.pins.highPull = BYTE_ZERO;
                // program store strobe stays off both halves
                d.pins.psenN    = 1'b1;                   // see R9
                if (!half && addrWin)
                begin
                    d.pins.lowOut = d.dataAddr[7:0];      // see R1, see R18
                    d.pins.lowOe  = PORT_RESET;
                end
                else if (d.dataWrite)
                begin
                    d.pins.lowOut = d.dataWdata;          // see R1
                    d.pins.lowOe  = PORT_RESET;
                    d.pins.wrN    = 1'b0;
                end
                else
                begin
                    d.pins.lowOe  = BYTE_ZERO;
                    d.rdAct       = 1'b1;
                end
            end
            default:
            begin
                d.pins.ale = 1'b0;
            end
        endcase
        // strobes reach port 3 as alternate functions over the latch
        d.pins.rdN = cfg.rdLatch & ~d.rdAct;              // see R15
        if (!cfg.wrLatch)
            d.pins.wrN = 1'b0;                            // see R15

        // ------------------------------------------------------------
        // read capture, delayed to match the pin synchroniser
        // ------------------------------------------------------------
        d.fetchPipe = {q.fetchPipe[0], ~q.pins.psenN & d.pins.psenN};
        d.readPipe  = {q.readPipe[0], q.rdAct & ~d.rdAct};
        d.rsp.fetchValid = q.fetchPipe[1];
        d.rsp.dataValid  = q.readPipe[1];
        if (q.fetchPipe[1])
            d.rsp.fetchData = q.lowSync2;
        if (q.readPipe[1])
            d.rsp.dataRdata = q.lowSync2;

        if (!rstn)
        begin
            d.armed     = 1'b1;
            d.kind      = CYC_INT;
            d.codeAddr  = 16'h0000;
            d.dataWrite = 1'b0;
            d.dataWide  = 1'b0;
            d.dataAddr  = 16'h0000;
            d.dataWdata = BYTE_ZERO;
            d.rdAct     = 1'b0;
            d.fetchPipe = PIPE_ZERO;
            d.readPipe  = PIPE_ZERO;
            // ports sit at their all-ones reset picture
            d.pins.ale      = 1'b0;
            d.pins.psenN    = 1'b1;
            d.pins.rdN      = 1'b1;
            d.pins.wrN      = 1'b1;
            d.pins.lowOut   = BYTE_ZERO;
            d.pins.lowOe    = BYTE_ZERO;
            d.pins.highOut  = PORT_RESET;
            d.pins.highOe   = BYTE_ZERO;
            d.pins.highPull = PORT_RESET;
            d.rsp.reqTaken     = 1'b0;
            d.rsp.fetchValid   = 1'b0;
            d.rsp.fetchData    = BYTE_ZERO;
            d.rsp.dataValid    = 1'b0;
            d.rsp.dataRdata    = BYTE_ZERO;
            d.rsp.doubleSpeed  = 1'b0;
            d.rsp.extAccessLow = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        q <= d;
    end

    assign pins = q.pins;
    assign rsp  = q.rsp;

endmodule // ext_bus_if

// ### rtl/ext_bus_pkg.sv
package ext_bus_pkg;

    // ----------------------------------------------------------------
    // machine cycle timing, in oscillator periods
    // ----------------------------------------------------------------
    typedef logic [3:0] phase_t;

    // each machine cycle has two halves, one address/strobe slot each
    localparam phase_t HALF_LEN_12     = 4'h6;
    localparam phase_t HALF_LEN_6      = 4'h3;
    // last phase of a half in which the latch strobe is high
    localparam phase_t ALE_END_12      = 4'h1;
    localparam phase_t ALE_END_6       = 4'h0;
    // first phase of a half in which the program store strobe, or in the first half a read or write strobe, is low
    localparam phase_t STROBE_START_12 = 4'h3;
    localparam phase_t STROBE_START_6  = 4'h2;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PORT_RESET  = 8'hff;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;
    localparam logic [1:0] PIPE_ZERO   = 2'h0;

    // ----------------------------------------------------------------
    // kinds of machine cycle, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CYC_INT  = 3'b001,   // fetch from on-chip program memory
        CYC_EXT  = 3'b010,   // fetch from external program memory
        CYC_DATA = 3'b100    // external data move
    } cycle_e;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] codeAddr;      // address of first code byte
        logic        codeInternal;  // core says address is on-chip
        logic        dataReq;       // external data move this cycle
        logic        dataWrite;     // 1 write, 0 read
        logic        dataWide;      // 16-bit pointer address
        logic [15:0] dataAddr;      // data address (low byte if narrow)
        logic [7:0]  dataWdata;     // write data
    } cpu_req_s;

    typedef struct packed {
        logic [7:0] lowLatch;       // low port output latch
        logic [7:0] highLatch;      // high port output latch
        logic       rdLatch;        // port 3 bit 7 latch
        logic       wrLatch;        // port 3 bit 6 latch
        logic       aleOff;         // auxiliary control bit 0
        logic       softDouble;     // soft_double_speed_bit
        logic       otpDouble;      // otp_double_speed_option
    } port_cfg_s;

    typedef struct packed {
        logic       ale;            // address latch strobe
        logic       psenN;          // program_store_read_strobe, low
        logic       rdN;            // port 3 bit 7 read strobe, low
        logic       wrN;            // port 3 bit 6 write strobe, low
        logic [7:0] lowOut;         // low port output value
        logic [7:0] lowOe;          // low port strong drive enable
        logic [7:0] highOut;        // high port output value
        logic [7:0] highOe;         // high port strong drive enable
        logic [7:0] highPull;       // high port weak pull-up enable
    } bus_pins_s;

    typedef struct packed {
        logic       reqTaken;       // request sampled last cycle
        logic       fetchValid;     // code byte valid, pulse
        logic [7:0] fetchData;      // code byte
        logic       dataValid;      // read data valid, pulse
        logic [7:0] dataRdata;      // read data
        logic       doubleSpeed;    // 6-clock mode in force
        logic       extAccessLow;   // external_access_select latched low
    } cpu_rsp_s;

endpackage

// ### rtl/cycle_timer.sv
`timescale 1ns/1ps
module cycle_timer
(
    input  wire logic                  sys_clk,     // oscillator clock
    input  wire logic                  rstn,        // sync reset, low
    input  wire logic                  otpDouble,   // otp option
    input  wire logic                  softDouble,  // software bit
    output ext_bus_pkg::phase_t        phase,       // phase within half
    output logic                       half,        // which half
    output logic                       doubleSpeed  // 6-clock mode
);
    import ext_bus_pkg::*;

    typedef struct packed {
        phase_t phase;
        logic   half;
        logic   dbl;
    } timer_s;

    timer_s q;
    timer_s d;

    function automatic phase_t lastPhase(input logic dbl);
        lastPhase = dbl ? HALF_LEN_6 - 4'h1 : HALF_LEN_12 - 4'h1;
    endfunction

    always_comb
    begin
        d = q;
        if (q.phase == lastPhase(q.dbl))
        begin
            d.phase = 4'h0;
            d.half  = ~q.half;
            // mode only changes between machine cycles, never mid-cycle
            if (q.half)
                d.dbl = otpDouble | softDouble;  // see R14, see R17
        end
        else
            d.phase = q.phase + 4'h1;
        if (!rstn)
        begin
            d.phase = 4'h0;
            d.half  = 1'b0;
            d.dbl   = 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        q <= d;
    end

    assign phase       = q.phase;
    assign half        = q.half;
    assign doubleSpeed = q.dbl;

endmodule // cycle_timer

// ### test/ext_bus_if_props.sv
`timescale 1ns/1ps
module ext_bus_if_props
(
    input wire logic                   sys_clk, // oscillator clock
    input wire logic                   rstn,    // sync reset, low
    input wire ext_bus_pkg::port_cfg_s cfg,     // latches and options
    input wire ext_bus_pkg::bus_pins_s pins,    // bus pins
    input wire ext_bus_pkg::cpu_rsp_s  rsp      // answers to core
);
    import ext_bus_pkg::*;
    logic not12;
    // any hint of 6-clock mode aborts the 12-clock checks
    assign not12 = cfg.softDouble | cfg.otpDouble | rsp.doubleSpeed;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    sequence ale12_s;
        pins.ale [*2] ##1 !pins.ale;
    endsequence
    sequence psen12_s;
        !pins.psenN [*3] ##1 pins.psenN;
    endsequence
    sequence next12_s;
        (##6 $rose(pins.ale)) or (##12 $rose(pins.ale));
    endsequence
    sequence next6_s;
        (##3 $rose(pins.ale)) or (##6 $rose(pins.ale));
    endsequence
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    chk_ale_width:
        assert property (disable iff (!rstn || not12)
        $rose(pins.ale) |-> ale12_s) else $error("ale width");
    chk_ale_rate:
        assert property (disable iff (!rstn || not12 || cfg.aleOff)
        $rose(pins.ale) |-> next12_s) else $error("ale rate");
    chk_ale_fast:
        assert property (disable iff (!rstn || cfg.aleOff || !rsp.doubleSpeed)
        $rose(pins.ale) && $past(rsp.doubleSpeed, 8) |-> next6_s)
        else $error("fast ale rate");
    chk_addr_hold:
        assert property ($fell(pins.ale) |->
        $stable(pins.lowOut) && $stable(pins.lowOe)) else $error("addr moved");
    chk_ale_quiet:
        assert property (pins.ale |-> pins.psenN && pins.rdN && pins.wrN)
        else $error("strobe in ale");
    chk_program_store_read_strobe_width:
        assert property (disable iff (!rstn || not12)
        $fell(pins.psenN) |-> psen12_s) else $error("program_store_read_strobe width");
    chk_program_store_read_strobe_float:
        assert property (!pins.psenN |->
        pins.lowOe == 8'h00 && pins.highOe == 8'hff) else $error("program_store_read_strobe drive");
    chk_data_strobe:
        assert property (!pins.rdN || !pins.wrN |-> pins.psenN &&
        (pins.rdN || pins.wrN) && pins.lowOe == (pins.rdN ? 8'hff : 8'h00))
        else $error("data strobe");
    chk_ale_off:
        assert property ($rose(pins.ale) && cfg.aleOff && $past(cfg.aleOff, 8)
        |-> ##[1:12] (!pins.rdN || !pins.wrN)) else $error("ale not blocked");
    chk_ea_held:
        assert property (rstn && $past(rstn) && $past(rstn, 2) && $past(rstn, 3)
        |-> $stable(rsp.extAccessLow)) else $error("ea relatched");
endmodule // ext_bus_if_props

bind ext_bus_if ext_bus_if_props i_props (.sys_clk(sys_clk), .rstn(rstn),
    .cfg(cfg), .pins(pins), .rsp(rsp));

// ### test/ext_mem_model.sv
`timescale 1ns/1ps
module ext_mem_model
(
    input  wire logic                   sys_clk,   // oscillator clock
    input  wire ext_bus_pkg::bus_pins_s pins,      // bus pins
    output logic [7:0]                  lowPortIn, // low port level
    output logic [15:0]                 lastAddr,  // last strobed address
    output logic [7:0]                  wrData     // last written byte
);
    import ext_bus_pkg::*;
    logic [7:0] addrLo;
    logic [7:0] memOut;
    logic [7:0] lastLvl = 8'h00;
    logic [15:0] addr;
    // external latch, captures the low byte on the strobe's falling edge
    always @(negedge pins.ale) addrLo = pins.lowOut;
    assign addr = {pins.highOut, addrLo};
    assign memOut = !pins.psenN ? (addr[7:0] ^ addr[15:8] ^ 8'h5a)
                                : (~addr[7:0] ^ addr[15:8]);
    // a released line has no pull, so it wanders instead of holding
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            lowPortIn[i] = pins.lowOe[i] ? pins.lowOut[i] :
                (!pins.psenN || !pins.rdN) ? memOut[i] : ~lastLvl[i];
    end
    always @(posedge sys_clk)
    begin
        lastLvl <= lowPortIn;
        if (!pins.psenN || !pins.rdN || !pins.wrN)
            lastAddr <= addr;
        if (!pins.wrN)
            wrData <= pins.lowOut;
    end
endmodule // ext_mem_model

// ### test/ext_bus_if_tb.sv
`timescale 1ns/1ps
`define CHK(a, b, m) \
    begin \
        cmp_count++; \
        if ((a) !== (b)) \
        begin \
            failures++; \
            $display("CHECK FAILED %0t %s", $time, m); \
        end \
    end
module ext_bus_if_tb;
    import ext_bus_pkg::*;
    logic        sys_clk;
    logic        rstn;
    logic        eaPin;
    logic [7:0]  lowPortIn;
    logic [15:0] lastAddr;
    logic [7:0]  wrData;
    logic [7:0]  hiSeen;
    cpu_req_s    req;
    port_cfg_s   cfg;
    bus_pins_s   pins;
    cpu_rsp_s    rsp;
    int          failures;
    int          cmp_count;
    int          nAle, nPsen, nRd, nWr, nFv, nDv, sumF, sumD;

    ext_bus_if i_dut (.sys_clk(sys_clk), .rstn(rstn), .req(req), .cfg(cfg),
        .eaPin(eaPin), .lowPortIn(lowPortIn), .pins(pins), .rsp(rsp));
    ext_mem_model i_mem (.sys_clk(sys_clk), .pins(pins),
        .lowPortIn(lowPortIn), .lastAddr(lastAddr), .wrData(wrData));

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic doReset(input int n);
        rstn = 1'b0;
        repeat (n) tick();
        rstn = 1'b1;
    endtask
    // counts strobe edges over n clocks once only the new kind runs
    task automatic run(input cpu_req_s r, input int n);
        bus_pins_s p;
        int        k;
        req = r;
        k = 0;
        repeat (3)
        begin
            do
            begin
                tick();
                k++;
            end while (rsp.reqTaken !== 1'b1 && k < 60);
        end
        `CHK(k < 60, 1'b1, "no take")
        {nAle, nPsen, nRd, nWr, nFv, nDv, sumF, sumD} = '0;
        hiSeen = 8'h00;
        repeat (n)
        begin
            p = pins;
            tick();
            nAle += int'(pins.ale && !p.ale);
            nPsen += int'(!pins.psenN && p.psenN);
            nRd += int'(!pins.rdN && p.rdN);
            nWr += int'(!pins.wrN && p.wrN);
            nFv += int'(rsp.fetchValid);
            nDv += int'(rsp.dataValid);
            if (rsp.fetchValid) sumF += rsp.fetchData;
            if (rsp.dataValid) sumD += rsp.dataRdata;
            if (!(pins.psenN & pins.rdN & pins.wrN))
                hiSeen = pins.highOut & pins.highOe;
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_internal();
        cpu_req_s r;
        r = '0;
        r.codeInternal = 1'b1;
        run(r, 24);
        `CHK(nAle, 4, "ale rate")
        `CHK(nPsen, 0, "program_store_read_strobe on chip")
        `CHK(pins.highOe, 8'h00, "high oe")
        `CHK(pins.highPull, 8'h3c, "high pull")
        `CHK(pins.lowOe, 8'hf0, "low float")
        $display("internal fetch done");
    endtask
    task automatic t_fetch();
        cpu_req_s r;
        r = '0;
        r.codeAddr = 16'h12a5;
        run(r, 24);
        `CHK(nAle, 4, "ale rate")
        `CHK(nPsen, 4, "program_store_read_strobe count")
        `CHK(nFv, 4, "fetch count")
        // code byte is addr low ^ addr high ^ 5a: ed and ee, twice each
        `CHK(sumF, 950, "code bytes")
        `CHK(hiSeen, 8'h12, "high addr")
        `CHK(lastAddr, 16'h12a6, "second addr")
        $display("external fetch done");
    endtask
    task automatic t_data(input logic wr, input logic wide, input int ales);
        cpu_req_s r;
        r = '0;
        r.dataReq = 1'b1;
        r.dataWrite = wr;
        r.dataWide = wide;
        r.dataAddr = wr ? 16'h0077 : 16'hbe3c;
        r.dataWdata = 8'h96;
        run(r, 24);
        `CHK(nAle, ales, "ale skip")
        `CHK(nPsen, 0, "program_store_read_strobe skip")
        `CHK(nRd, wr ? 0 : 2, "rd count")
        `CHK(nWr, wr ? 2 : 0, "wr count")
        `CHK(hiSeen, wide ? 8'hbe : 8'h3c, "high port")
        `CHK(lastAddr, wide ? 16'hbe3c : 16'h3c77, "data addr")
        if (wr)
            `CHK(wrData, 8'h96, "write data")
        else
            `CHK(sumD, 250, "read data")
        $display("data move done");
    endtask
    task automatic t_fast();
        cpu_req_s r;
        r = '0;
        r.codeAddr = 16'h12a5;
        cfg.softDouble = 1'b1;
        run(r, 12);
        `CHK(nAle, 4, "fast ale")
        `CHK(nPsen, 4, "fast program_store_read_strobe")
        `CHK(rsp.doubleSpeed, 1'b1, "soft bit")
        cfg.softDouble = 1'b0;
        cfg.otpDouble = 1'b1;
        run(r, 12);
        `CHK(nAle, 4, "otp ale")
        `CHK(nPsen, 4, "otp program_store_read_strobe")
        `CHK(rsp.doubleSpeed, 1'b1, "otp wins")
        cfg.otpDouble = 1'b0;
        doReset(24);
        `CHK(rsp.doubleSpeed, 1'b0, "slow default")
        run(r, 24);
        `CHK(nAle, 4, "slow ale")
        `CHK(nPsen, 4, "slow program_store_read_strobe")
        `CHK(rsp.doubleSpeed, 1'b0, "slow kept")
        $display("clock mode done");
    endtask
    task automatic t_ale_off();
        cfg.aleOff = 1'b1;
        run('0, 24);
        `CHK(nAle, 0, "ale off")
        `CHK(nPsen, 4, "code still runs")
        $display("latch strobe off done");
        t_data(1'b0, 1'b1, 2);
        cfg.aleOff = 1'b0;
    endtask
    task automatic t_ea();
        cpu_req_s r;
        r = '0;
        r.codeInternal = 1'b1;
        eaPin = 1'b0;
        doReset(24);
        repeat (3) tick();
        eaPin = 1'b1;
        run(r, 24);
        `CHK(rsp.extAccessLow, 1'b1, "ea latched")
        `CHK(nPsen, 4, "all external")
        doReset(24);
        repeat (3) tick();
        `CHK(rsp.extAccessLow, 1'b0, "ea high")
        $display("access pin done");
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rstn = 1'b0;
        eaPin = 1'b1;
        req = '0;
        cfg = '0;
        cfg.lowLatch = 8'h0f;
        cfg.highLatch = 8'h3c;
        cfg.rdLatch = 1'b1;
        cfg.wrLatch = 1'b1;
        failures = 0;
        cmp_count = 0;
        repeat (2) tick();
        `CHK(pins.psenN, 1'b1, "reset program_store_read_strobe")
        `CHK(pins.ale, 1'b0, "reset ale")
        rstn = 1'b1;
        t_internal();
        t_fetch();
        t_data(1'b0, 1'b1, 2);
        t_data(1'b1, 1'b0, 2);
        t_ale_off();
        t_fast();
        t_ea();
        print_verdict();
    end
    initial
    begin
        // about ten runs of some sixty clocks, with wide margin
        #(25 * 5000);
        failures++;
        print_verdict();
    end
endmodule // ext_bus_if_tb
